// ===== compare_pkg.sv
// Constants shared by the compare match unit: register offsets, field layout and mode codes.
// Assumes an AHB-Lite slave with 32-bit words, one register per aligned word.
package compare_pkg;

  localparam logic [7:0] OFS_UNIT1_CONTROL = 8'h00;
  localparam logic [7:0] OFS_UNIT2_CONTROL = 8'h04;
  localparam logic [7:0] OFS_UNIT1_VALUE_HIGH = 8'h08;
  localparam logic [7:0] OFS_UNIT1_VALUE_LOW = 8'h0C;
  localparam logic [7:0] OFS_UNIT2_VALUE_HIGH = 8'h10;
  localparam logic [7:0] OFS_UNIT2_VALUE_LOW = 8'h14;
  localparam logic [7:0] OFS_UNIT_TIMER_SELECT = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h24;

  localparam logic [7:0] UNIT1_CONTROL_MASK = 8'hFF;
  localparam logic [7:0] UNIT2_CONTROL_MASK = 8'h3F;
  localparam int UNIT1_TIMER_CHOICE_BIT = 0;
  localparam int UNIT2_TIMER_CHOICE_BIT = 3;
  localparam logic [7:0] TIMER_SELECT_MASK = 8'h09;
  localparam logic [7:0] IRQ_MASK = 8'h03;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam logic [7:0] TIMER_SELECT_RESET = 8'h00;
  localparam logic [15:0] TIMER_CLEAR_VALUE = 16'h0000;

  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_SET = 4'h8;
  localparam logic [3:0] MODE_CLEAR = 4'h9;
  localparam logic [3:0] MODE_SOFT_IRQ = 4'hA;
  localparam logic [3:0] MODE_SPECIAL = 4'hB;

endpackage : compare_pkg

// ===== timer_compare_match_unit.sv
// Two compare match units behind an AHB-Lite register slave.
// Assumes both 16-bit timers are counted elsewhere on hclk and clear on timer_reset pulses.
// Operation
// - Compare all 16 value bits against all 16 selected timer bits every cycle.
// - The compared count comes from timer one or timer three only.
// - On match, mode picks toggle, set, clear, special trigger or soft interrupt.
// - Every match in modes 0010 through 1011 sets the unit flag on the next edge; other modes leave it.
// - Both units behave identically except that only unit two starts conversion and stores six control bits.
// - Unimplemented bits read as zero and ignore writes.
// - Mode 1010 sets only the flag and leaves the pin uncontrolled.
// - Mode 1011 flags, unit two starts conversion if ADC and trigger are enabled, and the timer resets, all on the same next edge, without overflow.
// - Clearing a control register forces that unit's output latch low.
// - Each unit picks its own timer through its select bit.
`timescale 1ns/1ns
`default_nettype none
module timer_compare_match_unit
  import compare_pkg::*;
#(
  parameter int UNITS = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] timer1_count,
  input wire logic [15:0] timer3_count,
  input wire logic adc_enabled,
  input wire logic conversion_trigger_source,
  output logic timer1_reset,
  output logic timer3_reset,
  output logic conversion_start,
  output logic [UNITS-1:0] unit_output_pin_o,
  output logic [UNITS-1:0] unit_output_pin_oe,
  output logic irq
);

  function automatic logic drives_pin(input logic [3:0] mode);
    drives_pin = (mode == MODE_TOGGLE) || (mode == MODE_SET) || (mode == MODE_CLEAR);
  endfunction : drives_pin

  logic [7:0] control_q [UNITS];
  logic [15:0] value_q [UNITS];
  logic [UNITS-1:0] choice_q;
  logic [UNITS-1:0] latch_q;
  logic [UNITS-1:0] flag_q;
  logic [UNITS-1:0] enable_q;
  logic [UNITS-1:0] match;
  logic [UNITS-1:0] special;
  logic [15:0] count [UNITS];
  logic [3:0] mode [UNITS];

  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic bus_req;
  logic [7:0] wbyte;
  logic [UNITS-1:0] clear_hit;

  assign bus_req = hsel && hready && htrans[1];
  assign wbyte = hwdata[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= bus_req && hwrite;
      if (bus_req) begin
        wr_addr_q <= haddr[7:0];
      end
    end
  end

  for (genvar u = 0; u < UNITS; u++) begin : g_unit
    localparam logic [7:0] OFS_CTRL = (u == 0) ? OFS_UNIT1_CONTROL : OFS_UNIT2_CONTROL;
    localparam logic [7:0] OFS_HIGH = (u == 0) ? OFS_UNIT1_VALUE_HIGH : OFS_UNIT2_VALUE_HIGH;
    localparam logic [7:0] OFS_LOW = (u == 0) ? OFS_UNIT1_VALUE_LOW : OFS_UNIT2_VALUE_LOW;
    localparam logic [7:0] CMASK = (u == 0) ? UNIT1_CONTROL_MASK : UNIT2_CONTROL_MASK;

    assign mode[u] = control_q[u][3:0];
    assign count[u] = choice_q[u] ? timer3_count : timer1_count;
    assign match[u] = (value_q[u] == count[u]);
    assign special[u] = match[u] && (mode[u] == MODE_SPECIAL);
    assign clear_hit[u] = wr_pend_q && (wr_addr_q == OFS_CTRL) && ((wbyte & CMASK) == 8'h00);

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        control_q[u] <= CONTROL_RESET;
        value_q[u] <= {VALUE_RESET, VALUE_RESET};
      end else if (wr_pend_q) begin
        if (wr_addr_q == OFS_CTRL) begin
          control_q[u] <= wbyte & CMASK;
        end
        if (wr_addr_q == OFS_HIGH) begin
          value_q[u][15:8] <= wbyte;
        end
        if (wr_addr_q == OFS_LOW) begin
          value_q[u][7:0] <= wbyte;
        end
      end
    end

    // Output latch follows the match action of its own unit.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        latch_q[u] <= 1'b0;
      end else if (clear_hit[u]) begin
        latch_q[u] <= 1'b0;
      end else if (match[u]) begin
        unique case (mode[u])
          MODE_TOGGLE: latch_q[u] <= !latch_q[u];
          MODE_SET: latch_q[u] <= 1'b1;
          MODE_CLEAR: latch_q[u] <= 1'b0;
          default: latch_q[u] <= latch_q[u];
        endcase
      end
    end

    // Flag: a match in the clearing cycle wins over the clear.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        flag_q[u] <= 1'b0;
      end else if (match[u] && (mode[u] >= MODE_TOGGLE) && (mode[u] <= MODE_SPECIAL)) begin
        flag_q[u] <= 1'b1;
      end else if (wr_pend_q && (wr_addr_q == OFS_IRQ_CLEAR) && wbyte[u]) begin
        flag_q[u] <= 1'b0;
      end
    end

    assign unit_output_pin_o[u] = latch_q[u];
    assign unit_output_pin_oe[u] = drives_pin(mode[u]);

    match_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
      match[u] && (mode[u] == MODE_SET) && !clear_hit[u] |=> flag_q[u] && latch_q[u])
      else $error("Flag or latch missed a set match.");

    clear_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
      clear_hit[u] |=> !latch_q[u])
      else $error("Output latch not low after control clear.");

    soft_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode[u] == MODE_SOFT_IRQ) |-> !unit_output_pin_oe[u])
      else $error("Soft interrupt mode drives the pin.");

    toggle_flip_a: assert property (@(posedge hclk) disable iff (!hresetn)
      match[u] && (mode[u] == MODE_TOGGLE) && !clear_hit[u] |=>
      latch_q[u] != $past(latch_q[u]))
      else $error("Toggle match did not flip latch.");

    compare_eq_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !choice_q[u] && (value_q[u] == timer1_count) |-> match[u])
      else $error("Equal timer one count gave no match.");

    timer3_eq_a: assert property (@(posedge hclk) disable iff (!hresetn)
      choice_q[u] && (value_q[u] == timer3_count) |-> match[u])
      else $error("Equal timer three count gave no match.");

    timer1_ne_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !choice_q[u] && (value_q[u] != timer1_count) |-> !match[u])
      else $error("Match against an unequal timer one count.");

    timer3_ne_a: assert property (@(posedge hclk) disable iff (!hresetn)
      choice_q[u] && (value_q[u] != timer3_count) |-> !match[u])
      else $error("Match against an unequal timer three count.");

    flag_any_a: assert property (@(posedge hclk) disable iff (!hresetn)
      match[u] && (mode[u] >= MODE_TOGGLE) && (mode[u] <= MODE_SPECIAL) |=> flag_q[u])
      else $error("Compare match did not set the flag.");

    flag_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !match[u] && !flag_q[u] |=> !flag_q[u])
      else $error("Flag set without a match.");

    flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_q && (wr_addr_q == OFS_IRQ_CLEAR) && wbyte[u] && !match[u] |=> !flag_q[u])
      else $error("Flag not cleared by a clear write.");

    clear_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
      match[u] && (mode[u] == MODE_CLEAR) |=> !latch_q[u])
      else $error("Clear match left the latch high.");

    latch_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !match[u] && !clear_hit[u] |=> $stable(latch_q[u]))
      else $error("Latch moved without a match.");

    soft_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode[u] == MODE_SOFT_IRQ) && !clear_hit[u] |=> $stable(latch_q[u]))
      else $error("Soft interrupt mode moved the latch.");

    special_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode[u] == MODE_SPECIAL) |-> !unit_output_pin_oe[u])
      else $error("Special event mode drives the pin.");

    drive_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode[u] == MODE_TOGGLE) || (mode[u] == MODE_SET) || (mode[u] == MODE_CLEAR) |->
      unit_output_pin_oe[u])
      else $error("Pin not driven in an output mode.");

    ctrl_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_q && (wr_addr_q == OFS_CTRL) |=> control_q[u] == $past(wbyte & CMASK))
      else $error("Control write did not land masked.");

    value_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_q && (wr_addr_q == OFS_HIGH) |=> value_q[u][15:8] == $past(wbyte))
      else $error("Value high byte write did not land.");

    value_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_q && (wr_addr_q == OFS_LOW) |=> value_q[u][7:0] == $past(wbyte))
      else $error("Value low byte write did not land.");
  end

  // Special event clears the chosen timer on the following edge without touching the pin.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer1_reset <= 1'b0;
      timer3_reset <= 1'b0;
      conversion_start <= 1'b0;
    end else begin
      timer1_reset <= (special[0] && !choice_q[0]) || (special[1] && !choice_q[1]);
      timer3_reset <= (special[0] && choice_q[0]) || (special[1] && choice_q[1]);
      conversion_start <= special[1] && adc_enabled && conversion_trigger_source;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      choice_q <= '0;
    end else if (wr_pend_q && (wr_addr_q == OFS_UNIT_TIMER_SELECT)) begin
      choice_q[0] <= wbyte[UNIT1_TIMER_CHOICE_BIT];
      choice_q[1] <= wbyte[UNIT2_TIMER_CHOICE_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_q <= '0;
    end else if (wr_pend_q && (wr_addr_q == OFS_IRQ_ENABLE)) begin
      enable_q <= wbyte[UNITS-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flag_q & enable_q);
    end
  end

  // Read data is registered at the address phase so it stands in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_req && !hwrite) begin
      unique case (haddr[7:0])
        OFS_UNIT1_CONTROL: hrdata <= {24'h000000, control_q[0]};
        OFS_UNIT2_CONTROL: hrdata <= {24'h000000, control_q[1]};
        OFS_UNIT1_VALUE_HIGH: hrdata <= {24'h000000, value_q[0][15:8]};
        OFS_UNIT1_VALUE_LOW: hrdata <= {24'h000000, value_q[0][7:0]};
        OFS_UNIT2_VALUE_HIGH: hrdata <= {24'h000000, value_q[1][15:8]};
        OFS_UNIT2_VALUE_LOW: hrdata <= {24'h000000, value_q[1][7:0]};
        OFS_UNIT_TIMER_SELECT: hrdata <= {28'h0000000, choice_q[1], 2'b00, choice_q[0]};
        OFS_IRQ_STATUS: hrdata <= {30'h0, flag_q};
        OFS_IRQ_ENABLE: hrdata <= {30'h0, enable_q};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  special_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    special[0] && !choice_q[0] |=> timer1_reset)
    else $error("Special event did not reset timer one.");

  conv_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    conversion_start |-> $past(special[1]) && $past(adc_enabled) &&
    $past(conversion_trigger_source))
    else $error("Conversion started without unit two special match.");

  irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 irq == $past(|(flag_q & enable_q)))
    else $error("Interrupt output disagrees with enabled flags.");

  ctrl_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
    control_q[1][7:6] == 2'b00)
    else $error("Unimplemented control bits set.");

  special3_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    special[0] && choice_q[0] |=> timer3_reset)
    else $error("Special event did not reset timer three.");

  unit2_t1_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    special[1] && !choice_q[1] |=> timer1_reset)
    else $error("Unit two special event did not reset timer one.");

  unit2_t3_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    special[1] && choice_q[1] |=> timer3_reset)
    else $error("Unit two special event did not reset timer three.");

  idle_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !special[0] && !special[1] |=> !timer1_reset && !timer3_reset)
    else $error("Timer reset without a special event.");

  conv_fire_a: assert property (@(posedge hclk) disable iff (!hresetn)
    special[1] && adc_enabled && conversion_trigger_source |=> conversion_start)
    else $error("Enabled conversion did not start.");

  conv_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !special[1] |=> !conversion_start)
    else $error("Conversion started without unit two event.");

  choice1_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && (wr_addr_q == OFS_UNIT_TIMER_SELECT) |=>
    choice_q[0] == $past(wbyte[UNIT1_TIMER_CHOICE_BIT]))
    else $error("Unit one timer choice write did not land.");

  choice2_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && (wr_addr_q == OFS_UNIT_TIMER_SELECT) |=>
    choice_q[1] == $past(wbyte[UNIT2_TIMER_CHOICE_BIT]))
    else $error("Unit two timer choice write did not land.");

  enable_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && (wr_addr_q == OFS_IRQ_ENABLE) |=> enable_q == $past(wbyte[UNITS-1:0]))
    else $error("Enable write did not land.");

  status_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_req && !hwrite && (haddr[7:0] == OFS_IRQ_STATUS) |=> hrdata == {30'h0, $past(flag_q)})
    else $error("Status read disagrees with flags.");

  clear_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_req && !hwrite && (haddr[7:0] == OFS_IRQ_CLEAR) |=> hrdata == 32'h0000_0000)
    else $error("Clear register did not read zero.");

  select_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_req && !hwrite && (haddr[7:0] == OFS_UNIT_TIMER_SELECT) |=>
    (hrdata & ~{24'h000000, TIMER_SELECT_MASK}) == 32'h0000_0000)
    else $error("Unimplemented select bits read nonzero.");

  ctrl2_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_req && !hwrite && (haddr[7:0] == OFS_UNIT2_CONTROL) |=> hrdata[31:6] == 26'h0)
    else $error("Unimplemented control bits read nonzero.");

  value_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_req && !hwrite && (haddr[7:0] == OFS_UNIT1_VALUE_LOW) |=>
    hrdata == {24'h000000, $past(value_q[0][7:0])})
    else $error("Value low byte read disagrees.");

  unmapped_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_req && !hwrite && (haddr[7:0] > OFS_IRQ_CLEAR) |=> hrdata == 32'h0000_0000)
    else $error("Unmapped read did not return zero.");

endmodule : timer_compare_match_unit
`default_nettype wire

// ===== compare_pin_load.sv
// Pin load model: what stands on each compare output pad.
// Assumes a pull-down on every pad, so a released pad reads low.
`timescale 1ns/1ns
`default_nettype none
module compare_pin_load #(
  parameter int UNITS = 2
) (
  input wire logic [UNITS-1:0] drive,
  input wire logic [UNITS-1:0] oe,
  output logic [UNITS-1:0] pad
);
  // The pad follows the latch only while driven, else the pull-down wins.
  assign pad = oe & drive;
endmodule : compare_pin_load
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the compare match unit over AHB-Lite.
// Assumes the package and the pin load model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench import compare_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, rd_pend, pin_chk, l, oe, adc_en, trig;
  logic hreadyout, hresp, tr1, tr3, cst, irq;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [1:0] htrans, po, poe, pad;
  logic [2:0] hsize;
  logic [15:0] t1, t3, v;
  logic [7:0] b;
  logic [3:0] n1, n3, nc;
  logic [3:0] ml [7] = '{MODE_TOGGLE, MODE_CLEAR, MODE_SET, MODE_SOFT_IRQ, MODE_SPECIAL,
    MODE_SPECIAL, MODE_SPECIAL};
  logic [31:0] q[$], pq[$];
  int fail_count, total_checks, u, e1, e3, ec;
  timer_compare_match_unit dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer1_count(t1),
    .timer3_count(t3), .adc_enabled(adc_en), .conversion_trigger_source(trig),
    .timer1_reset(tr1), .timer3_reset(tr3), .conversion_start(cst),
    .unit_output_pin_o(po), .unit_output_pin_oe(poe), .irq(irq));
  compare_pin_load load (.drive(po), .oe(poe), .pad(pad));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  task complete_run;
    $display("comparisons %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  task cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task wrdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 50) begin
      fail_count++;
      complete_run();
    end
  endtask : wrdy
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) begin
      q.push_back(e);
      rd_pend <= 1'b1;
    end
    wrdy();
    rd_pend <= 1'b0;
  endtask : bus
  task hit(input int s, input logic [15:0] x);
    @(posedge hclk);
    if (s == 0) t1 <= x; else t3 <= x;
    @(posedge hclk);
    t1 <= v ^ 16'h0001;
    t3 <= v ^ 16'h0001;
  endtask : hit
  task pchk(input logic [31:0] e);
    repeat (3) @(posedge hclk);
    pq.push_back(e);
    pin_chk <= 1'b1;
    @(posedge hclk);
    pin_chk <= 1'b0;
  endtask : pchk
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {n1, n3, nc} <= 12'h000;
    end else begin
      n1 <= n1 + {3'h0, tr1};
      n3 <= n3 + {3'h0, tr3};
      nc <= nc + {3'h0, cst};
    end
  end
  always @(posedge hclk) begin
    if (rd_pend) cmp(hrdata, q.pop_front());
    if (pin_chk) cmp({15'h0, n1, n3, nc, 1'b0, irq, poe[u], po[u], pad[u]}, pq.pop_front());
  end
  initial begin
    {hsel, hwrite, rd_pend, pin_chk, l, oe, adc_en, trig} = 8'h03;
    {htrans, haddr, hwdata, t1, t3, v, b} = '0;
    hsize = 3'h2;
    hresetn = 1'b0;
    {fail_count, total_checks, u, e1, e3, ec} = '0;
    seed = 32'hBCB3B452;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, OFS_UNIT1_CONTROL, 0, {24'h0, CONTROL_RESET});
    bus(1, OFS_UNIT2_CONTROL, 32'hFFFFFFFF, 0);
    bus(0, OFS_UNIT2_CONTROL, 0, {24'h0, UNIT2_CONTROL_MASK});
    bus(1, 8'h40, 32'hFFFFFFFF, 0);
    bus(0, 8'h40, 0, 0);
    bus(1, OFS_UNIT2_CONTROL, 0, 0);
    bus(1, OFS_IRQ_ENABLE, 1, 0);
    for (u = 0; u < 2; u++) begin
      seed = nx(seed);
      v = seed[15:0];
      t1 <= v ^ 16'h0001;
      t3 <= v ^ 16'h0001;
      b = {4'h0, u[0], 3'h0};
      bus(1, OFS_UNIT_TIMER_SELECT, 32'hFF, 0);
      bus(0, OFS_UNIT_TIMER_SELECT, 0, {24'h0, TIMER_SELECT_MASK});
      bus(1, OFS_UNIT_TIMER_SELECT, {28'h0, u[0], 3'h0}, 0);
      bus(1, OFS_UNIT1_VALUE_HIGH + b, {24'h0, v[15:8]}, 0);
      bus(1, OFS_UNIT1_VALUE_LOW + b, {24'h0, v[7:0]}, 0);
      bus(0, OFS_UNIT1_VALUE_HIGH + b, 0, {24'h0, v[15:8]});
      for (int k = 0; k < 7; k++) begin
        bus(1, OFS_UNIT1_CONTROL + (b >> 1), {28'h0, ml[k]}, 0);
        adc_en <= (k != 5);
        trig <= (k != 6);
        hit(1 - u, v);
        hit(u, v ^ 16'h8000);
        hit(u, v);
        oe = k < 3;
        if (k == 0) l = ~l; else if (k < 3) l = (k == 2);
        e1 += (k >= 4 && u == 0);
        e3 += (k >= 4 && u == 1);
        ec += (k == 4 && u == 1);
        pchk({15'h0, e1[3:0], e3[3:0], ec[3:0], 1'b0, u == 0, oe, l, oe & l});
        bus(0, OFS_IRQ_STATUS, 0, 32'h1 << u);
        bus(1, OFS_IRQ_CLEAR, 32'h1 << u, 0);
      end
      bus(1, OFS_UNIT1_CONTROL + (b >> 1), 0, 0);
      l = 1'b0;
      pchk({15'h0, e1[3:0], e3[3:0], ec[3:0], 5'h00});
    end
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge hclk);
    fail_count++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
